/* File: ppp_pkg.sv */
// Shared constants, field layout and pin carriers of the parallel printer port
// What this block does
// - Data readback address returns the data latch.
// - Status bit 7 shows the inverted printer busy line.
// - Status bit 6 shows live acknowledge level.
// - Status bit 5 set means paper out.
// - Status bit 4 set means printer selected.
// - Status bit 3 low means printer fault.
// - Control address write stores printer control bits.
// - Control address read returns stored control latch.
// - Bit 4 enables interrupt on acknowledge rise.
// - Control bit 3 drives select printer output.
// - Control bit 1 drives automatic line feed.
package ppp_pkg;

  // ==========================================================================
  // Register offsets on the three address lines
  localparam logic [2:0] PPP_ADDR_DATA = 3'h0;
  localparam logic [2:0] PPP_ADDR_STATUS = 3'h1;
  localparam logic [2:0] PPP_ADDR_CTRL = 3'h2;

  // ==========================================================================
  // Status field positions
  localparam int PPP_ST_BUSY_N = 7;
  localparam int PPP_ST_ACK_N = 6;
  localparam int PPP_ST_PAPER_OUT = 5;
  localparam int PPP_ST_SELECTED = 4;
  localparam int PPP_ST_FAULT_N = 3;

  // ==========================================================================
  // Control field positions
  localparam int PPP_CT_IRQ_EN = 4;
  localparam int PPP_CT_SELECT = 3;
  localparam int PPP_CT_INIT_N = 2;
  localparam int PPP_CT_AUTO_LF = 1;
  localparam int PPP_CT_STROBE = 0;
  localparam int PPP_CT_WIDTH = 5;

  // ==========================================================================
  // Reset values
  localparam logic [4:0] PPP_CTRL_RESET = 5'h04;
  localparam logic [7:0] PPP_LATCH_RESET = 8'h00;

  // ==========================================================================
  // Timing kept by software and printer, at a 25 MHz clock
  localparam int PPP_CLK_MHZ = 25;
  localparam real PPP_INIT_MIN_US = 50.0;
  localparam real PPP_STROBE_MIN_US = 0.5;
  localparam real PPP_SETUP_MIN_US = 0.5;
  localparam real PPP_ACK_TYP_US = 5.0;
  localparam int PPP_INIT_MIN_CYC = int'($ceil(PPP_INIT_MIN_US * PPP_CLK_MHZ));
  localparam int PPP_STROBE_MIN_CYC = int'($ceil(PPP_STROBE_MIN_US * PPP_CLK_MHZ));
  localparam int PPP_SETUP_MIN_CYC = int'($ceil(PPP_SETUP_MIN_US * PPP_CLK_MHZ));
  localparam int PPP_ACK_TYP_CYC = int'($floor(PPP_ACK_TYP_US * PPP_CLK_MHZ));

  // ==========================================================================
  // Pin carriers
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_out;
    logic printer_selected;
    logic fault_n;
  } ppp_prn_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic strobe;
    logic auto_linefeed;
    logic init_n;
    logic select_printer;
  } ppp_prn_out_t;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [2:0] addr;
    logic [7:0] data;
  } ppp_cpu_in_t;

  // ==========================================================================
  // Idle pin levels, loaded into the synchronisers at reset so no false edge follows it
  localparam ppp_cpu_in_t PPP_CPU_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, data: 8'h00};
  localparam ppp_prn_in_t PPP_PRN_IDLE = '{busy: 1'b0, ack_n: 1'b1, paper_out: 1'b0,
                                          printer_selected: 1'b0, fault_n: 1'b1};

endpackage : ppp_pkg

/* File: ppp_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module ppp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import ppp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ppp_sync_t;

  ppp_sync_t st;
  ppp_sync_t next_st;

  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '{s1: RESET_VALUE, s2: RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;
endmodule : ppp_sync

/* File: ppp_fifo.sv */
// Character FIFO with valid and ready on both sides
`timescale 1ns/100ps
module ppp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import ppp_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } ppp_fifo_t;

  ppp_fifo_t st;
  ppp_fifo_t next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (st.wr_ptr == st.rd_ptr);
  assign full = (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]) && (st.wr_ptr[AW] != st.rd_ptr[AW]);
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[st.rd_ptr[AW-1:0]];

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage needs no reset; only the pointers do
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[st.wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
endmodule : ppp_fifo

/* File: ppp_port.sv */
// Parallel printer port: processor registers, character FIFO and printer pins
`timescale 1ns/100ps
module ppp_port #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire ppp_pkg::ppp_cpu_in_t cpu_in,
  output logic [7:0] cpu_data_out,
  output logic cpu_data_oe_n_out,
  output logic cpu_wr_ready_out,
  input wire ppp_pkg::ppp_prn_in_t prn_in,
  output ppp_pkg::ppp_prn_out_t prn_out,
  output logic irq_out
);
  import ppp_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [PPP_CT_WIDTH-1:0] ctrl;
    logic [7:0] latch;
    logic latch_full;
    logic irq;
    logic wr_n_d;
    logic rd_n_d;
    logic ack_n_d;
    logic [7:0] rd_data;
    logic rd_oe_n;
  } ppp_core_t;

  ppp_core_t st;
  ppp_core_t next_st;

  // ==========================================================================
  // Input synchronisation
  ppp_cpu_in_t cpu_s;
  ppp_prn_in_t prn_s;

  ppp_sync #(
    .WIDTH($bits(ppp_cpu_in_t)),
    .RESET_VALUE(PPP_CPU_IDLE)
  ) u_sync_cpu (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(cpu_in),
    .sync_out(cpu_s)
  );

  ppp_sync #(
    .WIDTH($bits(ppp_prn_in_t)),
    .RESET_VALUE(PPP_PRN_IDLE)
  ) u_sync_prn (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(prn_in),
    .sync_out(prn_s)
  );

  // ==========================================================================
  // Character FIFO between processor writes and the data latch
  logic push_valid;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;

  ppp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push_valid),
    .in_ready_out(cpu_wr_ready_out),
    .in_data_in(cpu_s.data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );

  // ==========================================================================
  // Bus strobes: writes complete on the rising edge of the write strobe
  logic wr_done;
  logic rd_done;
  logic rd_active;
  logic ack_rise;
  logic strobe_rise;
  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;

  assign wr_done = !st.wr_n_d && cpu_s.wr_n && !cpu_s.cs_n;
  assign rd_done = !st.rd_n_d && cpu_s.rd_n && !cpu_s.cs_n;
  assign rd_active = !cpu_s.rd_n && !cpu_s.cs_n;
  assign ack_rise = !st.ack_n_d && prn_s.ack_n;
  assign push_valid = wr_done && (cpu_s.addr == PPP_ADDR_DATA);
  assign strobe_rise = wr_done && (cpu_s.addr == PPP_ADDR_CTRL) &&
                       cpu_s.data[PPP_CT_STROBE] && !st.ctrl[PPP_CT_STROBE];

  // Next character moves into the latch only while the strobe is idle,
  // the printer is free and the previous character has been strobed;
  // never in the cycle that raises the strobe, so data cannot move under it
  assign fifo_pop = fifo_valid && !st.latch_full && !st.ctrl[PPP_CT_STROBE] && !prn_s.busy && !strobe_rise;

  // ==========================================================================
  // Status and control read images
  always_comb begin
    status_byte = 8'h00;
    status_byte[PPP_ST_BUSY_N] = !prn_s.busy;
    status_byte[PPP_ST_ACK_N] = prn_s.ack_n;
    status_byte[PPP_ST_PAPER_OUT] = prn_s.paper_out;
    status_byte[PPP_ST_SELECTED] = prn_s.printer_selected;
    status_byte[PPP_ST_FAULT_N] = prn_s.fault_n;
    ctrl_byte = {{(8 - PPP_CT_WIDTH){1'b0}}, st.ctrl};
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.wr_n_d = cpu_s.wr_n;
    next_st.rd_n_d = cpu_s.rd_n;
    next_st.ack_n_d = prn_s.ack_n;

    if (wr_done && (cpu_s.addr == PPP_ADDR_CTRL)) begin
      next_st.ctrl = cpu_s.data[PPP_CT_WIDTH-1:0];
    end

    // Character strobed out frees the latch for the next one
    if (strobe_rise) begin
      next_st.latch_full = 1'b0;
    end
    if (fifo_pop) begin
      next_st.latch = fifo_data;
      next_st.latch_full = 1'b1;
    end

    // interrupt on acknowledge rise, set wins over clear
    if (!st.ctrl[PPP_CT_IRQ_EN]) begin
      next_st.irq = 1'b0;
    end else if (ack_rise) begin
      next_st.irq = 1'b1;
    end else if (rd_done && (cpu_s.addr == PPP_ADDR_STATUS)) begin
      next_st.irq = 1'b0;
    end

    // Read data registered every cycle, driven while chip select and read strobe are low
    next_st.rd_oe_n = !rd_active;
    case (cpu_s.addr)
      PPP_ADDR_DATA: begin
        next_st.rd_data = st.latch;
      end
      PPP_ADDR_STATUS: begin
        next_st.rd_data = status_byte;
      end
      PPP_ADDR_CTRL: begin
        next_st.rd_data = ctrl_byte;
      end
      default: begin
        next_st.rd_data = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st.ctrl <= PPP_CTRL_RESET;
      st.latch <= PPP_LATCH_RESET;
      st.latch_full <= 1'b0;
      st.irq <= 1'b0;
      st.wr_n_d <= 1'b1;
      st.rd_n_d <= 1'b1;
      st.ack_n_d <= 1'b1;
      st.rd_data <= 8'h00;
      st.rd_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    prn_out.data = st.latch;
    prn_out.strobe = st.ctrl[PPP_CT_STROBE];
    prn_out.auto_linefeed = st.ctrl[PPP_CT_AUTO_LF];
    prn_out.init_n = st.ctrl[PPP_CT_INIT_N];
    prn_out.select_printer = st.ctrl[PPP_CT_SELECT];
  end

  assign cpu_data_out = st.rd_data;
  assign cpu_data_oe_n_out = st.rd_oe_n;
  assign irq_out = st.irq;
endmodule : ppp_port

/* File: ppp_printer_model.sv */
// Behavioural printer that takes characters from the port
`timescale 1ns/100ps
module ppp_printer_model (
  input wire logic ref_clk_in,
  input wire ppp_pkg::ppp_prn_out_t pins_in,
  input wire logic [7:0] wait_in,
  input wire logic [2:0] cond_in,
  output ppp_pkg::ppp_prn_in_t pins_out
);
  import ppp_pkg::*;
  logic [7:0] got[$];
  logic busy = 1'b0;
  logic ack_n = 1'b1;
  assign pins_out = '{busy, ack_n, cond_in[2], cond_in[1], cond_in[0]};
  initial begin
    forever begin
      @(posedge pins_in.strobe);
      got.push_back(pins_in.data);
      busy <= 1'b1;
      repeat (wait_in) @(posedge ref_clk_in);
      ack_n <= 1'b0;
      repeat (PPP_ACK_TYP_CYC) @(posedge ref_clk_in);
      busy <= 1'b0;
      @(posedge ref_clk_in);
      ack_n <= 1'b1;
    end
  end
endmodule : ppp_printer_model

/* File: ppp_port_assertions.sv */
// Port checker for the parallel printer port
`timescale 1ns/100ps
module ppp_port_assertions (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire ppp_pkg::ppp_cpu_in_t cpu_in,
  input wire logic [7:0] cpu_data_out,
  input wire logic cpu_data_oe_n_out,
  input wire logic cpu_wr_ready_out,
  input wire ppp_pkg::ppp_prn_in_t prn_in,
  input wire ppp_pkg::ppp_prn_out_t prn_out,
  input wire logic irq_out
);
  import ppp_pkg::*;
  logic [2:0] up;
  logic rd, st, ct, un;
  assign rd = !cpu_in.cs_n && !cpu_in.rd_n;
  assign st = rd && cpu_in.addr == PPP_ADDR_STATUS;
  assign ct = rd && cpu_in.addr == PPP_ADDR_CTRL;
  assign un = rd && cpu_in.addr > 3'h2;
  // Cycles since reset, masks stale synchroniser stages
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_read_drive: assert property (up == 3'h7 && $past(rd, 3) && $past(rd, 4) |-> !cpu_data_oe_n_out)
    else $error("read data not driven");
  a_read_release: assert property (up == 3'h7 && !$past(rd, 3) && !$past(rd, 4) |-> cpu_data_oe_n_out)
    else $error("read data driven while idle");
  a_status_low_zero: assert property ($past(st, 3) && $past(st, 4) && $past(st, 5) |-> cpu_data_out[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_ctrl_high_zero: assert property ($past(ct, 3) && $past(ct, 4) && $past(ct, 5) |-> cpu_data_out[7:5] == 3'h0)
    else $error("control high bits not zero");
  a_unmapped_zero: assert property ($past(un, 3) && $past(un, 4) && $past(un, 5) |-> cpu_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_status_busy_live: assert property (
    $past(st, 3) && $past(st, 4) && $past(st, 5) |-> cpu_data_out[7] == !$past(prn_in.busy, 3))
    else $error("status busy bit wrong");
  a_status_ack_live: assert property (
    $past(st, 3) && $past(st, 4) && $past(st, 5) |-> cpu_data_out[6] == $past(prn_in.ack_n, 3))
    else $error("status acknowledge bit wrong");
  a_data_hold_strobe: assert property (prn_out.strobe && $past(prn_out.strobe) |-> $stable(prn_out.data))
    else $error("data moved during strobe");
  a_irq_ack_rise: assert property ($rose(irq_out) |-> $past(prn_in.ack_n, 2) && !$past(prn_in.ack_n, 8))
    else $error("interrupt without acknowledge rise");
  a_irq_after_reset: assert property (up < 3'h2 |-> !irq_out)
    else $error("interrupt right after reset");
endmodule : ppp_port_assertions
bind ppp_port ppp_port_assertions chk (.ref_clk_in, .sys_rst_in, .cpu_in, .cpu_data_out, .cpu_data_oe_n_out,
  .cpu_wr_ready_out, .prn_in, .prn_out, .irq_out);

/* File: ppp_port_test.sv */
// Self-checking bench for the parallel printer port
`timescale 1ns/100ps
module ppp_port_test;
  import ppp_pkg::*;
  localparam int DEPTH = 4;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  ppp_cpu_in_t bus = '{1'b1, 1'b1, 1'b1, 3'h0, 8'h00};
  logic [7:0] rdata, cpu_data_out;
  logic [7:0] wait_v = 8'h01;
  logic [2:0] cond = 3'h5;
  ppp_prn_in_t prn_in;
  ppp_prn_out_t prn_out;
  logic oe_n, wr_ready, irq;
  logic irq_exp = 1'b0;
  logic [31:0] seed = 32'hD98F5727;
  logic [7:0] q[$];
  int err_total = 0;
  int compares = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  ppp_port #(.FIFO_DEPTH(DEPTH)) dut (.ref_clk_in, .sys_rst_in, .cpu_in(bus), .cpu_data_out,
    .cpu_data_oe_n_out(oe_n), .cpu_wr_ready_out(wr_ready), .prn_in, .prn_out, .irq_out(irq));
  ppp_printer_model prn (.ref_clk_in, .pins_in(prn_out), .wait_in(wait_v), .cond_in(cond), .pins_out(prn_in));
  // ==========
  // Tasks
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cyc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus.cs_n <= 1'b0;
    bus.addr <= a;
    bus.data <= d;
    cyc(1);
    bus.wr_n <= 1'b0;
    cyc(4);
    bus.wr_n <= 1'b1;
    cyc(5);
    bus.cs_n <= 1'b1;
    cyc(4);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    bus.cs_n <= 1'b0;
    bus.addr <= a;
    cyc(1);
    bus.rd_n <= 1'b0;
    cyc(7);
    rdata = cpu_data_out;
    chk("oe_n", 8'h00, {7'h0, oe_n});
    bus.rd_n <= 1'b1;
    cyc(1);
    bus.cs_n <= 1'b1;
    cyc(5);
  endtask : rd
  task automatic wait_idle();
    int n;
    n = 0;
    while (prn_in.busy !== 1'b0 && n < 400) begin
      cyc(1);
      n++;
    end
    cyc(16);
    chk("irq", {7'h0, irq_exp}, {7'h0, irq});
  endtask : wait_idle
  task automatic summarize();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // ==========
  // Sequence
  initial begin
    cyc(3);
    sys_rst_in <= 1'b0;
    cyc(5);
    rd(PPP_ADDR_CTRL);
    chk("ctrl_reset", {3'h0, PPP_CTRL_RESET}, rdata);
    chk("init_reset", 8'h01, {7'h0, prn_out.init_n});
    for (int i = 0; i < 6; i++) begin
      logic [7:0] v;
      v = rnd() & 8'hFE;
      wr(PPP_ADDR_CTRL, v);
      rd(PPP_ADDR_CTRL);
      chk("ctrl", v & 8'h1F, rdata);
      chk("select", {7'h0, v[3]}, {7'h0, prn_out.select_printer});
      chk("autolf", {7'h0, v[1]}, {7'h0, prn_out.auto_linefeed});
      chk("init", {7'h0, v[2]}, {7'h0, prn_out.init_n});
      if (!v[2])
        cyc(PPP_INIT_MIN_CYC);
      cond <= v[7:5];
      cyc(4);
      rd(PPP_ADDR_STATUS);
      chk("status", {2'h3, v[7:5], 3'h0}, rdata);
      rd(3'h3 + 3'(i % 5));
      chk("unmapped", 8'h00, rdata);
    end
    wr(PPP_ADDR_CTRL, 8'h0C);
    for (int i = 0; i < DEPTH + 2; i++) begin
      logic [7:0] d;
      d = rnd();
      if (i <= DEPTH)
        q.push_back(d);
      wr(PPP_ADDR_DATA, d);
    end
    chk("ready", 8'h00, {7'h0, wr_ready});
    for (int k = 0; k < q.size(); k++) begin
      logic [7:0] v;
      wait_idle();
      rd(PPP_ADDR_STATUS);
      chk("irq_clear", 8'h00, {7'h0, irq});
      rd(PPP_ADDR_DATA);
      chk("latch", q[k], rdata);
      v = rnd();
      wait_v <= {2'h0, v[7:2]} | 8'h01;
      wr(PPP_ADDR_CTRL, {3'h0, v[0], 4'hD});
      cyc(PPP_STROBE_MIN_CYC);
      wr(PPP_ADDR_CTRL, {3'h0, v[0], 4'hC});
      rd(PPP_ADDR_STATUS);
      chk("busy", 8'h00, {rdata[7], 7'h0});
      irq_exp = v[0];
    end
    wait_idle();
    chk("ready", 8'h01, {7'h0, wr_ready});
    chk("count", 8'(DEPTH + 1), 8'(prn.got.size()));
    for (int i = 0; i < q.size(); i++)
      chk("printed", q[i], prn.got[i]);
    summarize();
  end
  initial begin
    cyc(60000);
    err_total++;
    summarize();
  end
endmodule : ppp_port_test
